// [verilog/mfmpg_pkg.sv]
// Constants, types and helpers shared by the MFM phase-compare gate
package mfmpg_pkg;

    // Master clock
    localparam int CLK_PERIOD_NS = 10;

    // Data rate selection codes
    typedef enum logic [1:0] {
        RATE_500  = 2'h0,
        RATE_300  = 2'h1,
        RATE_250  = 2'h2,
        RATE_1000 = 2'h3
    } mfmpg_rate_t;

    // Bit cell lengths per rate
    localparam int CELL_NS_250  = 4000;
    localparam int CELL_NS_300  = 3333;
    localparam int CELL_NS_500  = 2000;
    localparam int CELL_NS_1000 = 1000;

    // Quarter cell delay per rate, in ns
    localparam int QUARTER_NS_250  = CELL_NS_250 / 4;
    localparam int QUARTER_NS_300  = CELL_NS_300 / 4;
    localparam int QUARTER_NS_500  = 500;
    localparam int QUARTER_NS_1000 = CELL_NS_1000 / 4;

    // Counter widths
    localparam int PER_W  = 9;   // Oscillator period / phase
    localparam int TS_W   = 10;  // Delay-line time stamps
    localparam int FACC_W = 6;   // Frequency integrator

    // Loop constants
    localparam int FIFO_DEPTH   = 4;
    localparam int FREQ_ACC_LIM = 16;
    localparam int TRIM_SHIFT   = 4;  // Trim range = nominal / 16

    // Phase detector states
    typedef enum logic [2:0] {
        PD_IDLE = 3'h1,
        PD_UP   = 3'h2,
        PD_DN   = 3'h4
    } mfmpg_pd_t;

    // Reset values
    localparam logic [FACC_W-1:0] FACC_RST = 6'h00;
    localparam logic [TS_W-1:0]   TS_RST   = 10'h000;
    localparam logic [PER_W-1:0]  PH_RST   = 9'h000;

    // Half cell (one oscillator period) in clock cycles
    function automatic logic [PER_W-1:0] half_cycles(input mfmpg_rate_t rate);
        case (rate)
            RATE_250:  half_cycles = PER_W'(CELL_NS_250 / 2 / CLK_PERIOD_NS);
            RATE_300:  half_cycles = PER_W'(CELL_NS_300 / 2 / CLK_PERIOD_NS);
            RATE_1000: half_cycles = PER_W'(CELL_NS_1000 / 2 / CLK_PERIOD_NS);
            default:   half_cycles = PER_W'(CELL_NS_500 / 2 / CLK_PERIOD_NS);
        endcase
    endfunction

    // Quarter cell in clock cycles
    function automatic logic [TS_W-1:0] quarter_cycles(input mfmpg_rate_t rate);
        case (rate)
            RATE_250:  quarter_cycles = TS_W'(QUARTER_NS_250 / CLK_PERIOD_NS);
            RATE_300:  quarter_cycles = TS_W'(QUARTER_NS_300 / CLK_PERIOD_NS);
            RATE_1000: quarter_cycles = TS_W'(QUARTER_NS_1000 / CLK_PERIOD_NS);
            default:   quarter_cycles = TS_W'(QUARTER_NS_500 / CLK_PERIOD_NS);
        endcase
    endfunction

    // Allowed frequency trim around nominal period
    function automatic logic [PER_W-1:0] trim_span(input logic [PER_W-1:0] nom);
        trim_span = nom >> TRIM_SHIFT;
    endfunction

endpackage

// [verilog/mfmpg_fifo.sv]
// Small flip-flop FIFO carrying delayed-pulse time stamps
`timescale 1ns/1ps
module mfmpg_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap naturally, so depth must be a power of two
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("mfmpg_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage
    logic [AW-1:0]    wr_ptr_reg;        // Next slot to write
    logic [AW-1:0]    rd_ptr_reg;        // Head slot
    logic [AW:0]      count_reg;         // Occupancy
    logic             push;
    logic             pop;

    // Honest full and empty from occupancy
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            case ({push, pop})
                2'b10:   count_reg <= count_reg + 1'b1;
                2'b01:   count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end

endmodule

// [verilog/mfmpg_top.sv]
// Digital MFM data separator: quarter-cell delay, pulse gate, phase loop
`timescale 1ns/1ps
module mfmpg_top
    import mfmpg_pkg::*;
(
    // Clock and reset
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    // Drive read channel
    input  wire logic       RDATA_IN,
    // Controller control, same clock domain
    input  wire logic       READ_GATE,
    input  wire logic [1:0] RATE_SEL,
    // Recovered clock and separated data
    output logic            RD_CLK,
    output logic            RD_DATA,
    output logic            RD_WIN,
    output logic            RD_STB,
    // Loop status
    output logic            PUMP_UP,
    output logic            PUMP_DN,
    output logic            OVERRUN
);

    // Reset release synchroniser
    logic rst_q1_reg;
    logic rst_n;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_q1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_q1_reg <= 1'b1;
            rst_n      <= rst_q1_reg;
        end
    end

    // Read pulse pin synchroniser and edge detect
    logic rd_s1_reg;        // First stage, only read by second
    logic rd_s2_reg;
    logic rd_s3_reg;
    logic rd_lvl_reg;       // Accepted level
    logic rise;             // Leading edge of a read pulse

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rd_s1_reg  <= 1'b0;
            rd_s2_reg  <= 1'b0;
            rd_s3_reg  <= 1'b0;
            rd_lvl_reg <= 1'b0;
        end else begin
            rd_s1_reg <= RDATA_IN;
            rd_s2_reg <= rd_s1_reg;
            rd_s3_reg <= rd_s2_reg;
            // Level moves only when stages two and three agree
            if (rd_s2_reg == rd_s3_reg) begin
                rd_lvl_reg <= rd_s3_reg;
            end
        end
    end

    assign rise = rd_s2_reg && rd_s3_reg && !rd_lvl_reg;

    // Rate setting and nominal counts
    mfmpg_rate_t      rate_reg;
    logic [PER_W-1:0] half_nom_reg;    // Nominal oscillator period
    logic [TS_W-1:0]  quarter_reg;     // Quarter-cell delay
    logic             rate_chg;

    // Reset ratios fixed at elaboration so reset branches load constants only
    localparam logic [PER_W-1:0] HALF_RST    = half_cycles(RATE_500);
    localparam logic [TS_W-1:0]  QUARTER_RST = quarter_cycles(RATE_500);

    assign rate_chg = (mfmpg_rate_t'(RATE_SEL) != rate_reg);

    // Divide ratios follow the selected rate
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            rate_reg     <= RATE_500;
            half_nom_reg <= HALF_RST;
            quarter_reg  <= QUARTER_RST;
        end else begin
            rate_reg     <= mfmpg_rate_t'(RATE_SEL);
            half_nom_reg <= half_cycles(mfmpg_rate_t'(RATE_SEL));
            quarter_reg  <= quarter_cycles(mfmpg_rate_t'(RATE_SEL));
        end
    end

    // Reference divider: one tick per half cell, twice the data rate
    logic [PER_W-1:0] ref_cnt_reg;
    logic             ref_tick;

    assign ref_tick = (ref_cnt_reg == half_nom_reg - 1'b1);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_reg <= PH_RST;
        end else if (ref_tick || rate_chg) begin
            ref_cnt_reg <= PH_RST;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 1'b1;
        end
    end

    // Pulse source: reference while idle, drive pulses while reading
    logic src_pulse;

    assign src_pulse = READ_GATE ? rise : ref_tick;

    // Free-running time base for the delay line
    logic [TS_W-1:0] now_reg;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            now_reg <= TS_RST;
        end else begin
            now_reg <= now_reg + 1'b1;
        end
    end

    // Quarter-cell delay: each pulse that finds a free slot stores its due time in the FIFO
    logic            dl_in_ready;
    logic            dl_out_valid;
    logic [TS_W-1:0] dl_out_data;
    logic            dly_due;
    logic            dly_pulse;      // Delayed pulse into the detector

    assign dly_due   = (dl_out_data == now_reg);
    assign dly_pulse = dl_out_valid && dly_due;

    mfmpg_fifo #(
        .WIDTH (TS_W),
        .DEPTH (FIFO_DEPTH)
    ) u_delay (
        .clk       (MCLK),
        .rst_n     (rst_n),
        .in_valid  (src_pulse),
        .in_ready  (dl_in_ready),
        .in_data   (TS_W'(now_reg + quarter_reg)),   // Due time wraps with the time base
        .out_valid (dl_out_valid),
        .out_ready (dly_due),
        .out_data  (dl_out_data)
    );

    // Sticky overrun: a pulse met a full delay line and was lost
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            OVERRUN <= 1'b0;
        end else if (src_pulse && !dl_in_ready) begin
            OVERRUN <= 1'b1;
        end else if (!READ_GATE) begin
            OVERRUN <= 1'b0;
        end
    end

    // Oscillator and phase detector signals
    mfmpg_pd_t        pd_state_reg;
    logic             tick_reg;        // Halves pump gain
    logic [PER_W-1:0] per_reg;         // Current oscillator period
    logic [PER_W-1:0] ph_reg;          // Oscillator phase
    logic [PER_W-1:0] ph_next;
    logic [PER_W:0]   ph_sum;
    logic [1:0]       step;
    logic [PER_W-1:0] half_per;
    logic             osc_edge;
    logic             boundary;        // Mid-point between two edges
    logic             gate_reg;        // Pulse gate: comparison enabled
    logic             cmp_done;

    // Phase step: pumping speeds up or slows the oscillator
    always_comb begin
        step = 2'h1;
        if (pd_state_reg == PD_UP && tick_reg) begin
            step = 2'h2;
        end else if (pd_state_reg == PD_DN && tick_reg) begin
            step = 2'h0;
        end
        ph_sum   = {1'b0, ph_reg} + (PER_W+1)'(step);
        osc_edge = (ph_sum >= {1'b0, per_reg});
        if (osc_edge) begin
            ph_next = PER_W'(ph_sum - {1'b0, per_reg});
        end else begin
            ph_next = ph_sum[PER_W-1:0];
        end
        half_per = per_reg >> 1;
        boundary = !osc_edge && (ph_reg < half_per) && (ph_next >= half_per);
    end

    // Oscillator phase: one edge per window, two per cell
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ph_reg   <= PH_RST;
            tick_reg <= 1'b0;
        end else begin
            ph_reg   <= ph_next;
            tick_reg <= !tick_reg;
        end
    end

    // Pulse gate: armed by the undelayed pulse, used by the delayed one
    assign cmp_done = dly_pulse || (pd_state_reg == PD_DN && boundary);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            gate_reg <= 1'b0;
        end else if (src_pulse) begin
            gate_reg <= 1'b1;
        end else if (cmp_done) begin
            gate_reg <= 1'b0;
        end
    end

    // Phase detector: compares delayed pulse against oscillator edge
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pd_state_reg <= PD_IDLE;
        end else begin
            case (pd_state_reg)
                PD_IDLE: begin
                    // Ungated edges make no comparison
                    if (gate_reg && dly_pulse && !osc_edge) begin
                        pd_state_reg <= PD_UP;
                    end else if (gate_reg && osc_edge && !dly_pulse) begin
                        pd_state_reg <= PD_DN;
                    end else begin
                        pd_state_reg <= PD_IDLE;
                    end
                end
                PD_UP: begin
                    if (osc_edge) begin
                        pd_state_reg <= PD_IDLE;
                    end
                end
                PD_DN: begin
                    // Pulse came late, or never came by the mid-point: drop the comparison
                    if (cmp_done) begin
                        pd_state_reg <= PD_IDLE;
                    end
                end
                default: pd_state_reg <= PD_IDLE;
            endcase
        end
    end

    // Frequency integrator: slow period trim, jitter averages out
    logic signed [FACC_W-1:0] facc_reg;
    logic [PER_W-1:0]         per_min;
    logic [PER_W-1:0]         per_max;

    assign per_min = half_nom_reg - trim_span(half_nom_reg);
    assign per_max = half_nom_reg + trim_span(half_nom_reg);

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            facc_reg <= FACC_RST;
            per_reg  <= HALF_RST;
        end else if (rate_chg) begin
            facc_reg <= FACC_RST;
            per_reg  <= half_cycles(mfmpg_rate_t'(RATE_SEL));
        end else if (pd_state_reg == PD_UP) begin
            // Many lead cycles needed before the period shrinks
            if (facc_reg == FACC_W'(FREQ_ACC_LIM - 1)) begin
                facc_reg <= FACC_RST;
                if (per_reg > per_min) begin
                    per_reg <= per_reg - 1'b1;
                end
            end else begin
                facc_reg <= facc_reg + 1'b1;
            end
        end else if (pd_state_reg == PD_DN) begin
            if (facc_reg == -FACC_W'(FREQ_ACC_LIM - 1)) begin
                facc_reg <= FACC_RST;
                if (per_reg < per_max) begin
                    per_reg <= per_reg + 1'b1;
                end
            end else begin
                facc_reg <= facc_reg - 1'b1;
            end
        end
        // No comparison leaves the period untouched
    end

    // Window decode: window centred on its edge, closed at mid-point
    logic win_hit_reg;

    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            win_hit_reg <= 1'b0;
            RD_DATA     <= 1'b0;
            RD_WIN      <= 1'b0;
            RD_STB      <= 1'b0;
        end else begin
            RD_STB <= 1'b0;
            if (boundary) begin
                // A pulse landing on the boundary belongs to the closing window
                RD_DATA     <= win_hit_reg || dly_pulse;
                RD_WIN      <= !RD_WIN;
                RD_STB      <= READ_GATE;
                win_hit_reg <= 1'b0;
            end else if (dly_pulse) begin
                win_hit_reg <= 1'b1;
            end
        end
    end

    // Recovered read clock and pump indicators
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            RD_CLK  <= 1'b0;
            PUMP_UP <= 1'b0;
            PUMP_DN <= 1'b0;
        end else begin
            RD_CLK  <= (ph_next < half_per);
            PUMP_UP <= (pd_state_reg == PD_UP);
            PUMP_DN <= (pd_state_reg == PD_DN);
        end
    end

endmodule

// [tb/mfmpg_props.sv]
// Port-level checker for the MFM phase-compare gate, with its bind
`timescale 1ns/1ps
module mfmpg_props (
    // Clock and reset
    input wire logic       MCLK,
    input wire logic       RST_N,
    // Drive and controller inputs
    input wire logic       RDATA_IN,
    input wire logic       READ_GATE,
    input wire logic [1:0] RATE_SEL,
    // Recovered clock, data and loop status
    input wire logic       RD_CLK,
    input wire logic       RD_DATA,
    input wire logic       RD_WIN,
    input wire logic       RD_STB,
    input wire logic       PUMP_UP,
    input wire logic       PUMP_DN,
    input wire logic       OVERRUN
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [10:0] quiet_reg;  // Cycles without a pulse while following
    // Quiet counter; saturates so it never wraps under the limit
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            quiet_reg <= 11'h000;
        end else if (RDATA_IN || !READ_GATE) begin
            quiet_reg <= 11'h000;
        end else if (quiet_reg != 11'h7FF) begin
            quiet_reg <= quiet_reg + 11'h001;
        end
    end
    // Gate low on two samples
    sequence s_gate_off;
        !READ_GATE ##1 !READ_GATE;
    endsequence
    // High half of a period, never under 8 cycles at any rate
    sequence s_clk_high;
        RD_CLK [*8];
    endsequence
    a_pump_excl: assert property (!(PUMP_UP && PUMP_DN))
        else $error("pump up and down together");
    a_stb_single: assert property (RD_STB |=> !RD_STB)
        else $error("strobe longer than one cycle");
    a_win_toggle: assert property (RD_STB |-> RD_WIN != $past(RD_WIN))
        else $error("window flag did not toggle at strobe");
    a_data_hold: assert property ($stable(RD_WIN) |-> $stable(RD_DATA))
        else $error("data changed inside a window");
    a_clk_high: assert property ($rose(RD_CLK) |-> s_clk_high)
        else $error("read clock high phase too short");
    a_clk_period: assert property ($rose(RD_CLK) |-> ##[1:300] $rose(RD_CLK))
        else $error("read clock stopped");
    a_stb_idle: assert property (s_gate_off |=> !RD_STB)
        else $error("strobe while idle");
    a_ovr_clear: assert property (s_gate_off |=> !OVERRUN)
        else $error("overrun not cleared while idle");
    a_quiet_pump: assert property (quiet_reg >= 11'h3E8 |-> !PUMP_UP && !PUMP_DN)
        else $error("pumping with no pulses");
endmodule

bind mfmpg_top mfmpg_props u_props (.MCLK(MCLK), .RST_N(RST_N), .RDATA_IN(RDATA_IN),
    .READ_GATE(READ_GATE), .RATE_SEL(RATE_SEL), .RD_CLK(RD_CLK), .RD_DATA(RD_DATA),
    .RD_WIN(RD_WIN), .RD_STB(RD_STB), .PUMP_UP(PUMP_UP), .PUMP_DN(PUMP_DN),
    .OVERRUN(OVERRUN));

// [tb/mfmpg_drive.sv]
// Behavioural drive read channel emitting MFM pulses on a cell grid
`timescale 1ns/1ps
module mfmpg_drive (
    // Clock
    input wire logic clk,
    // Peak detector output, driven low between pulses
    output logic     rdata
);
    logic prev_bit;  // Last data bit, decides clock pulses
    // Idle line
    initial begin
        rdata = 1'b0;
        prev_bit = 1'b0;
    end
    // One window of len cycles, 4-cycle pulse at pos when wanted
    task automatic window(input logic want, input int len, input int pos);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            rdata <= want && (i >= pos) && (i < pos + 4);
        end
    endtask
    // Bits sent first-to-last from bit n-1; pos sets early or late
    task automatic send(input logic [15:0] bits, input int n, input int half,
                        input int pos);
        for (int b = n - 1; b >= 0; b--) begin
            window(!bits[b] && !prev_bit, half, pos);
            window(bits[b], half, pos);
            prev_bit = bits[b];
        end
    endtask
    // Illegal pulse train, far denser than a quarter cell can hold
    task automatic burst(input int n);
        repeat (n) window(1'b1, 8, 0);
    endtask
endmodule

// [tb/testbench.sv]
// Self-checking bench for the MFM phase-compare gate
`timescale 1ns/1ps
module testbench;
    import mfmpg_pkg::*;
    // Design pins
    logic       MCLK;
    logic       RST_N;
    logic       READ_GATE;
    logic [1:0] RATE_SEL;
    wire logic  RDATA_IN;
    logic       RD_CLK;
    logic       RD_DATA;
    logic       RD_WIN;
    logic       RD_STB;
    logic       PUMP_UP;
    logic       PUMP_DN;
    logic       OVERRUN;
    wire logic [6:0] outs = {RD_CLK, RD_DATA, RD_WIN, RD_STB, PUMP_UP, PUMP_DN, OVERRUN};
    // Bookkeeping; counts from the monitor, checks and errors also from the check tasks
    int         n_errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         rise_cyc = 0;
    int         lat = 0;
    int         sent = 0;
    int         ones = 0;
    int         strobes = 0;
    int         ups = 0;
    int         dns = 0;
    logic       rdata_d = 1'b0;
    localparam int LIMIT = 60000;  // Whole run needs about 28000
    localparam int Q500  = QUARTER_NS_500 / CLK_PERIOD_NS;
    localparam int H500  = CELL_NS_500 / 2 / CLK_PERIOD_NS;

    mfmpg_top dut (.MCLK(MCLK), .RST_N(RST_N), .RDATA_IN(RDATA_IN), .READ_GATE(READ_GATE),
        .RATE_SEL(RATE_SEL), .RD_CLK(RD_CLK), .RD_DATA(RD_DATA), .RD_WIN(RD_WIN),
        .RD_STB(RD_STB), .PUMP_UP(PUMP_UP), .PUMP_DN(PUMP_DN), .OVERRUN(OVERRUN));
    mfmpg_drive u_drive (.clk(MCLK), .rdata(RDATA_IN));

    // 100 MHz clock
    always #5 MCLK = ~MCLK;

    // Monitor: pulses sent, decodes, pumps, latency, hang guard
    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        rdata_d <= RDATA_IN;
        if (RDATA_IN && !rdata_d) begin
            sent <= sent + 1;
            rise_cyc <= cyc;
        end
        if (RD_STB === 1'b1) begin
            strobes <= strobes + 1;
        end
        if (RD_STB === 1'b1 && RD_DATA === 1'b1) begin
            ones <= ones + 1;
            lat <= cyc - rise_cyc;
        end
        ups <= ups + int'(PUMP_UP === 1'b1);
        dns <= dns + int'(PUMP_DN === 1'b1);
        if (cyc == LIMIT) begin
            n_errors++;
            $display("Error at %0t: run did not finish", $time);
            give_verdict();
        end
    end

    // Counts within tol of expectation
    task automatic check_int(input int got, input int exp, input int tol, input string what);
        checks_done++;
        if (got < exp - tol || got > exp + tol) begin
            n_errors++;
            $display("Error at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask
    // Output bits, exact
    task automatic check_bits(input logic [6:0] got, input logic [6:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask
    // Half cell in cycles per rate code
    function automatic int nom_of(input int r);
        case (r)
            1: return CELL_NS_300 / 2 / CLK_PERIOD_NS;
            2: return CELL_NS_250 / 2 / CLK_PERIOD_NS;
            3: return CELL_NS_1000 / 2 / CLK_PERIOD_NS;
            default: return CELL_NS_500 / 2 / CLK_PERIOD_NS;
        endcase
    endfunction
    // Reset with a new rate; rate changes only here so periods never tear
    task automatic do_reset(input logic [1:0] rate);
        @(posedge MCLK);
        RST_N <= 1'b0;
        READ_GATE <= 1'b0;
        RATE_SEL <= rate;
        repeat (4) @(posedge MCLK);
        check_bits(outs, 7'h00, "outputs in reset");
        RST_N <= 1'b1;
        repeat (4) @(posedge MCLK);
    endtask
    // Idle lock: average period equals half cell at every rate
    task automatic t_rates();
        time t0;
        for (int r = 0; r < 4; r++) begin
            do_reset(2'(r));
            repeat (24) @(posedge RD_CLK);
            t0 = $time;
            repeat (8) @(posedge RD_CLK);
            check_int(int'(($time - t0) / CLK_PERIOD_NS), 8 * nom_of(r), 4, "period");
        end
        $display("Test idle rates done");
    endtask
    // Preamble then data: one decode per pulse, latency of sync, quarter-cell delay and half a window
    task automatic t_lock();
        int s0;
        int o0;
        int b0;
        do_reset(RATE_500);
        READ_GATE <= 1'b1;
        s0 = sent;
        o0 = ones;
        u_drive.send(16'h0000, 16, H500, H500 / 2);
        u_drive.send(16'hDB6D, 16, H500, H500 / 2);
        repeat (300) @(posedge MCLK);
        check_int(ones - o0, sent - s0, 0, "decoded ones");
        check_int(lat, 3 + Q500 + H500 / 2 + 1, 6, "latency");
        b0 = strobes;
        repeat (1100) @(posedge MCLK);
        check_int(strobes - b0, 1100 / H500, 1, "free strobes");
        $display("Test lock and decode done");
    endtask
    // One clock pulse shifted by shift cycles after a fresh preamble
    task automatic t_pump(input int shift, input logic early);
        int u0;
        int d0;
        u_drive.send(16'h0000, 8, H500, H500 / 2);
        u0 = ups;
        d0 = dns;
        u_drive.send(16'h0000, 1, H500, H500 / 2 + shift);
        if (early) begin
            check_int(int'(ups > u0), 1, 0, "pump up");
        end else begin
            check_int(int'(dns > d0), 1, 0, "pump down");
        end
        $display("Test shifted pulse done");
    endtask
    // Overfill the delay queue, hold, then clear by idling
    task automatic t_overrun();
        u_drive.burst(12);
        repeat (100) @(posedge MCLK);
        check_bits({6'h00, OVERRUN}, 7'h01, "overrun set");
        READ_GATE <= 1'b0;
        repeat (3) @(posedge MCLK);
        check_bits({6'h00, OVERRUN}, 7'h00, "overrun cleared");
        $display("Test overrun done");
    endtask
    // Counts and verdict, the only exit
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        MCLK = 1'b0;
        RST_N = 1'b0;
        READ_GATE = 1'b0;
        RATE_SEL = 2'h0;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        t_rates();
        t_lock();
        t_pump(-20, 1'b1);
        t_pump(20, 1'b0);
        t_overrun();
        give_verdict();
    end
endmodule
